// ==== hw/pvit_defs.svh ====
// Offsets, field positions, reset values and timing counts of the integrator and trim block.
`ifndef PVIT_DEFS_SVH
`define PVIT_DEFS_SVH
`define PVIT_ADDR_W 4
`define PVIT_A_CTRL 4'h0
`define PVIT_A_RANGE_MIN 4'h1
`define PVIT_A_SPAN_GAIN 4'h2
`define PVIT_A_ZERO_ADJ 4'h3
`define PVIT_A_TOT_LO 4'h4
`define PVIT_A_TOT_HI 4'h5
`define PVIT_A_STATUS 4'h6
`define PVIT_A_IRQ_STAT 4'h7
`define PVIT_A_IRQ_MASK 4'h8
`define PVIT_A_DATE_LO 4'h9
`define PVIT_A_DATE_HI 4'ha
`define PVIT_A_OUT_CMD 4'hb
`define PVIT_A_OUT_TRIM 4'hc
`define PVIT_A_PV_TRIM 4'hd
`define PVIT_CTRL_START 0
`define PVIT_CTRL_RESET 1
`define PVIT_CTRL_MINUTE 2
`define PVIT_CTRL_DATE_UPD 3
`define PVIT_ST_NVM_ERR 0
`define PVIT_ST_PERIOD_OK 1
`define PVIT_IRQ_TICK 0
`define PVIT_IRQ_NVM_DONE 1
`define PVIT_IRQ_NVM_ERR 2
`define PVIT_GAIN_RESET 16'h2710
`define PVIT_GAIN_DIV 10000
`define PVIT_PV_DIV 1000
`define PVIT_CLK_MHZ 125
`define PVIT_HOUR_MS 3600
`define PVIT_MINUTE_MS 60
`define PVIT_HOUR_CYC (`PVIT_HOUR_MS * 1000 * `PVIT_CLK_MHZ)
`define PVIT_MINUTE_CYC (`PVIT_MINUTE_MS * 1000 * `PVIT_CLK_MHZ)
`endif

// ==== hw/pvit_pkg.sv ====
// Types shared by the integrator and trim block.
package pvit_pkg;
   typedef struct packed {
      logic start;
      logic clr;
      logic minute;
   } pvit_ctrl_t;
   typedef enum logic [1:0] {NV_IDLE, NV_REQ, NV_WAIT} pvit_nv_t;
endpackage

// ==== hw/pvit_trim.sv ====
// Zero and span trim of one signed 16-bit value, registered output.
module pvit_trim (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic signed [15:0] x,
   input wire logic signed [15:0] range_min,
   input wire logic [15:0] gain,
   input wire logic signed [15:0] zero_adj,
   output logic signed [31:0] y_q
);
   logic signed [17:0] diff;
   logic signed [35:0] prod;
   logic signed [35:0] scaled;
   assign diff = 18'(x) - 18'(range_min);
   assign prod = 36'(diff) * $signed({20'h00000, gain});
   // Truncation toward zero keeps symmetric behaviour around the range minimum.
   assign scaled = prod / 36'sd10000;
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         y_q <= 32'h00000000;
      end else begin
         y_q <= 32'(scaled) + 32'(range_min) + 32'(zero_adj);
      end
   end
endmodule

// ==== hw/pvit_top.sv ====
// Process value trim, time integrator and adjustment date store control.
// Functional notes
// RULE_01: A failed date write to the non-volatile store sets the error flag and marks the period tracking invalid until a good update.
// RULE_02: The date update request bit stays high for as long as the store write runs and drops when it ends.
// RULE_03: In hour mode one sample enters the integral every 3.6 s and the total reads as two 16-bit words.
// RULE_04: In minute mode one sample enters the integral every 60 ms with the same two-word total.
// RULE_05: A constant value held for one time unit makes the total equal that value.
// RULE_06: The total is a signed 32-bit number and beyond its limits it simply wraps, which counts as undefined.
// RULE_07: Software uses start and reset to keep the total inside its signed range.
// RULE_08: The value is corrected by removing the range minimum, scaling by gain in steps of 0.0001, restoring the minimum and adding the zero offset.
// RULE_09: The commanded output value receives the same zero and span correction.
// RULE_10: Each tick adds one thousandth of the corrected value and the remainder is kept so no error builds up.
// RULE_11: The reset bit clears the total, and accumulation happens only while start is set.
`include "pvit_defs.svh"
module pvit_top #(
   parameter int HOUR_CYC = `PVIT_HOUR_CYC,
   parameter int MINUTE_CYC = `PVIT_MINUTE_CYC
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic signed [15:0] PV_IN,
   output logic signed [15:0] OUT_LEVEL,
   output logic NVM_WR_REQ,
   output logic [31:0] NVM_WR_DATE,
   input wire logic NVM_DONE,
   input wire logic NVM_FAIL,
   output logic UNIT_ERROR_LAMP,
   output logic IRQ
);
   pvit_pkg::pvit_ctrl_t ctrl_q;
   pvit_pkg::pvit_nv_t nv_q;
   logic upd_q;
   logic signed [15:0] range_min_q;
   logic [15:0] gain_q;
   logic signed [15:0] zero_adj_q;
   logic signed [15:0] out_cmd_q;
   logic [31:0] date_q;
   logic signed [31:0] total_q;
   logic signed [15:0] rem_q;
   logic [31:0] tick_cnt_q;
   logic tick_q;
   logic nvm_err_q;
   logic period_ok_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_mask_q;
   logic [2:0] irq_set;
   logic signed [15:0] pv_s1_q;
   logic signed [15:0] pv_s2_q;
   logic done_s1_q;
   logic done_s2_q;
   logic fail_s1_q;
   logic fail_s2_q;
   logic signed [31:0] pv_trim;
   logic signed [31:0] out_trim;
   logic signed [31:0] acc;
   logic signed [31:0] acc_q1000;
   logic signed [31:0] acc_r1000;
   logic [31:0] tick_lim;
   logic wr_ctrl;

   // Pins come from the front end and the store controller, both off this clock.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pv_s1_q <= 16'sh0000;
         pv_s2_q <= 16'sh0000;
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
         fail_s1_q <= 1'b0;
         fail_s2_q <= 1'b0;
      end else begin
         pv_s1_q <= PV_IN;
         pv_s2_q <= pv_s1_q;
         done_s1_q <= NVM_DONE;
         done_s2_q <= done_s1_q;
         fail_s1_q <= NVM_FAIL;
         fail_s2_q <= fail_s1_q;
      end
   end

   // RULE_08: input value trim
   pvit_trim u_pv_trim (
      .MCLK(MCLK),
      .RST(RST),
      .x(pv_s2_q),
      .range_min(range_min_q),
      .gain(gain_q),
      .zero_adj(zero_adj_q),
      .y_q(pv_trim)
   );

   // RULE_09: output command trim
   pvit_trim u_out_trim (
      .MCLK(MCLK),
      .RST(RST),
      .x(out_cmd_q),
      .range_min(range_min_q),
      .gain(gain_q),
      .zero_adj(zero_adj_q),
      .y_q(out_trim)
   );

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         OUT_LEVEL <= 16'sh0000;
      end else begin
         OUT_LEVEL <= out_trim[15:0];
      end
   end

   assign wr_ctrl = WR && (ADDR == `PVIT_A_CTRL);

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ctrl_q <= '0;
         range_min_q <= 16'sh0000;
         gain_q <= `PVIT_GAIN_RESET;
         zero_adj_q <= 16'sh0000;
         out_cmd_q <= 16'sh0000;
         date_q <= 32'hffffffff;
         irq_mask_q <= 3'h0;
      end else if (WR) begin
         unique case (ADDR)
            `PVIT_A_CTRL: begin
               ctrl_q.start <= WDATA[`PVIT_CTRL_START];
               ctrl_q.clr <= WDATA[`PVIT_CTRL_RESET];
               ctrl_q.minute <= WDATA[`PVIT_CTRL_MINUTE];
            end
            `PVIT_A_RANGE_MIN: range_min_q <= WDATA;
            `PVIT_A_SPAN_GAIN: gain_q <= WDATA;
            `PVIT_A_ZERO_ADJ: zero_adj_q <= WDATA;
            `PVIT_A_OUT_CMD: out_cmd_q <= WDATA;
            `PVIT_A_DATE_LO: date_q[15:0] <= WDATA;
            `PVIT_A_DATE_HI: date_q[31:16] <= WDATA;
            `PVIT_A_IRQ_MASK: irq_mask_q <= WDATA[2:0];
            default: begin
            end
         endcase
      end
   end

   // RULE_03: hour tick
   // RULE_04: minute tick
   assign tick_lim = ctrl_q.minute ? 32'(MINUTE_CYC - 1) : 32'(HOUR_CYC - 1);

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         tick_cnt_q <= 32'h00000000;
         tick_q <= 1'b0;
      end else if (!ctrl_q.start || ctrl_q.clr) begin
         tick_cnt_q <= 32'h00000000;
         tick_q <= 1'b0;
      end else if (tick_cnt_q >= tick_lim) begin
         tick_cnt_q <= 32'h00000000;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h00000001;
         tick_q <= 1'b0;
      end
   end

   // RULE_10: thousandth with carried remainder
   assign acc = pv_trim + 32'(rem_q);
   assign acc_q1000 = acc / 32'sd1000;
   assign acc_r1000 = acc - acc_q1000 * 32'sd1000;

   // RULE_11: clear and gated accumulation
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         total_q <= 32'sh00000000;
         rem_q <= 16'sh0000;
      end else if (ctrl_q.clr) begin
         total_q <= 32'sh00000000;
         rem_q <= 16'sh0000;
      end else if (ctrl_q.start && tick_q) begin
         // RULE_05: unit scaling, RULE_06: plain wrap
         total_q <= total_q + acc_q1000;
         rem_q <= acc_r1000[15:0];
      end
   end

   // RULE_02: request held during the write
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         nv_q <= pvit_pkg::NV_IDLE;
         upd_q <= 1'b0;
         NVM_WR_REQ <= 1'b0;
         NVM_WR_DATE <= 32'hffffffff;
      end else begin
         unique case (nv_q)
            pvit_pkg::NV_IDLE: begin
               if (wr_ctrl && WDATA[`PVIT_CTRL_DATE_UPD]) begin
                  nv_q <= pvit_pkg::NV_REQ;
                  upd_q <= 1'b1;
                  NVM_WR_REQ <= 1'b1;
                  NVM_WR_DATE <= date_q;
               end
            end
            pvit_pkg::NV_REQ: begin
               // Skip ahead once the store has dropped a stale done.
               if (!done_s2_q) begin
                  nv_q <= pvit_pkg::NV_WAIT;
               end
            end
            pvit_pkg::NV_WAIT: begin
               if (done_s2_q) begin
                  nv_q <= pvit_pkg::NV_IDLE;
                  upd_q <= 1'b0;
                  NVM_WR_REQ <= 1'b0;
               end
            end
         endcase
      end
   end

   // RULE_01: error flag on failed write
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         nvm_err_q <= 1'b0;
         period_ok_q <= 1'b0;
         UNIT_ERROR_LAMP <= 1'b0;
      end else begin
         if (nv_q == pvit_pkg::NV_WAIT && done_s2_q) begin
            nvm_err_q <= fail_s2_q;
            period_ok_q <= !fail_s2_q;
         end
         UNIT_ERROR_LAMP <= nvm_err_q;
      end
   end

   assign irq_set[`PVIT_IRQ_TICK] = ctrl_q.start && tick_q;
   assign irq_set[`PVIT_IRQ_NVM_DONE] = (nv_q == pvit_pkg::NV_WAIT) && done_s2_q;
   assign irq_set[`PVIT_IRQ_NVM_ERR] = (nv_q == pvit_pkg::NV_WAIT) && done_s2_q && fail_s2_q;

   // A new event in the clearing cycle survives the clear.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         irq_stat_q <= 3'h0;
      end else if (WR && ADDR == `PVIT_A_IRQ_STAT) begin
         irq_stat_q <= (irq_stat_q & ~WDATA[2:0]) | irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Both halves read live; software should read low then high while start is off.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         RDATA <= 16'h0000;
      end else if (RD) begin
         unique case (ADDR)
            `PVIT_A_CTRL: RDATA <= {12'h000, upd_q, ctrl_q.minute, ctrl_q.clr, ctrl_q.start};
            `PVIT_A_RANGE_MIN: RDATA <= range_min_q;
            `PVIT_A_SPAN_GAIN: RDATA <= gain_q;
            `PVIT_A_ZERO_ADJ: RDATA <= zero_adj_q;
            `PVIT_A_TOT_LO: RDATA <= total_q[15:0];
            `PVIT_A_TOT_HI: RDATA <= total_q[31:16];
            `PVIT_A_STATUS: RDATA <= {14'h0000, period_ok_q, nvm_err_q};
            `PVIT_A_IRQ_STAT: RDATA <= {13'h0000, irq_stat_q};
            `PVIT_A_IRQ_MASK: RDATA <= {13'h0000, irq_mask_q};
            `PVIT_A_DATE_LO: RDATA <= date_q[15:0];
            `PVIT_A_DATE_HI: RDATA <= date_q[31:16];
            `PVIT_A_OUT_CMD: RDATA <= out_cmd_q;
            `PVIT_A_OUT_TRIM: RDATA <= out_trim[15:0];
            `PVIT_A_PV_TRIM: RDATA <= pv_trim[15:0];
            default: RDATA <= 16'h0000;
         endcase
      end else begin
         RDATA <= 16'h0000;
      end
   end
endmodule

// ==== sim/pvit_props.sv ====
// Port checks of the integrator and trim block.
`include "pvit_defs.svh"
module pvit_props #(
   parameter int HOUR_CYC = 100,
   parameter int MINUTE_CYC = 10
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   input wire logic signed [15:0] OUT_LEVEL,
   input wire logic NVM_WR_REQ,
   input wire logic [31:0] NVM_WR_DATE,
   input wire logic NVM_DONE,
   input wire logic NVM_FAIL,
   input wire logic UNIT_ERROR_LAMP
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   a_rdata_idle: assert property (!RD |=> RDATA == 16'h0)
      else $error("read data not idle");
   a_rdata_unmapped: assert property (RD && ADDR == 4'hf |=> RDATA == 16'h0)
      else $error("unmapped read not zero");
   a_req_cause: assert property ($rose(NVM_WR_REQ) |->
      $past(WR && ADDR == `PVIT_A_CTRL && WDATA[`PVIT_CTRL_DATE_UPD])) else $error("stray request");
   a_req_holds: assert property (NVM_WR_REQ && !NVM_DONE |=> NVM_WR_REQ)
      else $error("request dropped early");
   a_req_ends: assert property ($rose(NVM_DONE) && NVM_WR_REQ |-> ##[1:4] !NVM_WR_REQ)
      else $error("request not released");
   a_date_held: assert property (NVM_WR_REQ && $past(NVM_WR_REQ) |-> $stable(NVM_WR_DATE))
      else $error("date moved");
   a_lamp_fail: assert property ($fell(NVM_WR_REQ) |=> UNIT_ERROR_LAMP == $past(NVM_FAIL))
      else $error("lamp wrong");
   a_lamp_cause: assert property ($changed(UNIT_ERROR_LAMP) |->
      $past(NVM_WR_REQ, 2) && !$past(NVM_WR_REQ)) else $error("lamp moved alone");
   a_out_quiet: assert property (!$past(WR) && !$past(WR, 2) && !$past(WR, 3) &&
      !$past(WR, 4) |-> $stable(OUT_LEVEL)) else $error("output moved");
endmodule
bind pvit_top pvit_props #(.HOUR_CYC(HOUR_CYC), .MINUTE_CYC(MINUTE_CYC)) pvit_props_inst (
   .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .OUT_LEVEL(OUT_LEVEL), .NVM_WR_REQ(NVM_WR_REQ), .NVM_WR_DATE(NVM_WR_DATE),
   .NVM_DONE(NVM_DONE), .NVM_FAIL(NVM_FAIL), .UNIT_ERROR_LAMP(UNIT_ERROR_LAMP));

// ==== sim/pvit_nvm_model.sv ====
// Behavioural model of the date store.
module pvit_nvm_model #(
   parameter int DELAY = 5
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic req,
   input wire logic fail_mode,
   output logic done,
   output logic fail
);
   int cnt;
   // On release fail flips, so a stale flag can never pass as a real one.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cnt <= 0;
         done <= 1'b0;
         fail <= 1'b0;
      end else if (!req) begin
         cnt <= 0;
         done <= 1'b0;
         if (done) begin
            fail <= ~fail;
         end
      end else if (cnt < DELAY) begin
         cnt <= cnt + 1;
      end else begin
         done <= 1'b1;
         fail <= fail_mode;
      end
   end
endmodule

// ==== sim/pvit_top_tb_top.sv ====
// Self-checking bench of the integrator and trim block.
`include "pvit_defs.svh"
module pvit_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic [3:0] ADDR = 4'h0;
   logic [15:0] WDATA = 16'h0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic signed [15:0] PV_IN = 16'sh0;
   logic fail_mode = 1'b0;
   logic [15:0] RDATA;
   logic signed [15:0] OUT_LEVEL;
   logic NVM_WR_REQ, NVM_DONE, NVM_FAIL, UNIT_ERROR_LAMP, IRQ;
   logic [31:0] NVM_WR_DATE;
   int errors = 0;
   int compares = 0;
   always #4 MCLK = ~MCLK;
   pvit_top #(.HOUR_CYC(100), .MINUTE_CYC(10)) pvit_top_inst (.MCLK(MCLK), .RST(RST),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PV_IN(PV_IN),
      .OUT_LEVEL(OUT_LEVEL), .NVM_WR_REQ(NVM_WR_REQ), .NVM_WR_DATE(NVM_WR_DATE),
      .NVM_DONE(NVM_DONE), .NVM_FAIL(NVM_FAIL), .UNIT_ERROR_LAMP(UNIT_ERROR_LAMP), .IRQ(IRQ));
   pvit_nvm_model pvit_nvm_model_inst (.MCLK(MCLK), .RST(RST), .req(NVM_WR_REQ),
      .fail_mode(fail_mode), .done(NVM_DONE), .fail(NVM_FAIL));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input string name, input logic [3:0] a, input logic [15:0] exp);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1;
      chk(name, {16'h0, exp}, {16'h0, RDATA});
   endtask
   task automatic trim(input logic [15:0] x);
      PV_IN <= x;
      repeat (6) @(posedge MCLK);
      rd("pv trim", `PVIT_A_PV_TRIM, 16'((int'($signed(x)) - 100) * 10060 / 10000 + 105));
   endtask
   task automatic integ(input logic [2:0] c, input int span, input logic [31:0] exp);
      wr(`PVIT_A_CTRL, {13'h0, c});
      repeat (span) @(posedge MCLK);
      wr(`PVIT_A_CTRL, 16'h0);
      rd("total lo", `PVIT_A_TOT_LO, exp[15:0]);
      rd("total hi", `PVIT_A_TOT_HI, exp[31:16]);
   endtask
   task automatic nvm(input logic f, input logic [15:0] lo);
      int n;
      fail_mode <= f;
      wr(`PVIT_A_DATE_LO, lo);
      wr(`PVIT_A_DATE_HI, ~lo);
      wr(`PVIT_A_CTRL, 16'h0008);
      #1;
      chk("date", {~lo, lo}, NVM_WR_DATE);
      rd("busy", `PVIT_A_CTRL, 16'h0008);
      n = 0;
      while (NVM_WR_REQ !== 1'b0 && n < 50) begin
         @(posedge MCLK);
         #1;
         n++;
      end
      repeat (2) @(posedge MCLK);
      #1;
      chk("lamp", {31'h0, f}, {31'h0, UNIT_ERROR_LAMP});
      rd("status", `PVIT_A_STATUS, {14'h0, ~f, f});
   endtask
   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge MCLK);
      RST <= 1'b0;
      rd("gain", `PVIT_A_SPAN_GAIN, `PVIT_GAIN_RESET);
      rd("date", `PVIT_A_DATE_HI, 16'hffff);
      rd("unmapped", 4'hf, 16'h0);
      wr(`PVIT_A_RANGE_MIN, 16'h0064);
      wr(`PVIT_A_SPAN_GAIN, 16'h274c);
      wr(`PVIT_A_ZERO_ADJ, 16'h0005);
      wr(`PVIT_A_OUT_CMD, 16'h03e8);
      trim(16'h01f4);
      trim(16'hfc18);
      rd("out trim", `PVIT_A_OUT_TRIM, 16'h03f2);
      chk("out level", 32'h03f2, {16'h0, OUT_LEVEL});
      wr(`PVIT_A_RANGE_MIN, 16'h0);
      wr(`PVIT_A_SPAN_GAIN, `PVIT_GAIN_RESET);
      wr(`PVIT_A_ZERO_ADJ, 16'h0);
      PV_IN <= 16'sd1500;
      integ(3'b101, 33, 32'h4);
      integ(3'b001, 330, 32'h9);
      integ(3'b000, 40, 32'h9);
      integ(3'b010, 2, 32'h0);
      PV_IN <= -16'sd1500;
      integ(3'b101, 33, 32'hfffffffc);
      wr(`PVIT_A_IRQ_MASK, 16'h0001);
      @(posedge MCLK);
      #1;
      chk("irq", 32'h1, {31'h0, IRQ});
      wr(`PVIT_A_IRQ_STAT, 16'h0001);
      repeat (2) @(posedge MCLK);
      #1;
      chk("irq", 32'h0, {31'h0, IRQ});
      nvm(1'b1, 16'h1234);
      nvm(1'b0, 16'h4321);
      rd("irq stat", `PVIT_A_IRQ_STAT, 16'h0006);
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge MCLK);
      errors++;
      end_of_test();
   end
endmodule
